// ### core/dss_pkg.sv
// Purpose: shared constants and types for disc sector sensing
// Assumes: 40 MHz system clock, APB register access
// Notes: all offsets are byte addresses of 32-bit words
package dss_pkg;

  // clock and timing
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned IDX_PULSE_NS = 3310;
  localparam int unsigned IDX_PULSE_CYC =
    (IDX_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned MS_CYC_DEF = (MS_NS / 1000) * CLK_MHZ / 1000 * 1000;

  // sector geometry
  localparam logic [2:0] REF_DIV_LAST = 3'h7;
  localparam logic [9:0] SEC_DIV_LAST = 10'h347;
  localparam logic [9:0] SEC_END_CNT = 10'h330;
  localparam logic [5:0] SEC_LAST = 6'h3f;
  localparam logic [5:0] LOOKAHEAD_SECS = 6'h02;
  localparam int unsigned SHIFT_LEN = 7;
  localparam int unsigned PATTERN_LEN = 6;
  localparam logic [5:0] INDEX_PATTERN_DEF = 6'h2d;

  // register map
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] ADDR_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam int unsigned SEEK_CHECK_BIT = 3;

  // reset values and revolution counter width
  localparam logic [5:0] SEC_ADDR_RST = 6'h00;
  localparam int unsigned REV_W = 24;

  typedef struct packed {
    logic [3:0] unitNum;
    logic seekDone;
    logic writeCmd;
    logic readCmd;
  } dss_ctrl_t;

  localparam dss_ctrl_t CTRL_RST = '0;

endpackage : dss_pkg

// ### core/dss_sector_sense.sv
// Purpose: sector clock division, index detection, sector counting,
//   sector compare and look-ahead poll gating
// Assumes: sector clock, peak detect, pack clear and strap arrive
//   asynchronously; software drives read, write, seek done over APB
// Notes: one clock domain; pins pass two flip-flops before use
//
// What this block does
// R1 - divide sector clock by eight into reference, paced index detector
// R2 - delay flop catches peak detect, shifts into seven-stage register
// R3 - after six-bit index pattern seen, index pulse on next ref trailing edge
// R4 - index pulse stays asserted for 3.31 microseconds
// R5 - count sector clock transitions modulo 840, advance sector counter
// R6 - revolution is 53,760 transitions, giving 64 sectors
// R7 - index pulse clears divider and sector counter
// R8 - pack clear forces sector address register to zero
// R9 - controller supplies six-bit address, stored only when legal
// R10 - address illegal when its two upper bits are both set
// R11 - illegal address keeps register, sets seek check status bit 3
// R12 - compare stored address with present sector, clock on equality
// R13 - equality during read or write sets sector match
// R14 - sector match holds until count 816 or command withdrawn
// R15 - with look-ahead strapped, poll answered only in unit+1 ms window
// R16 - look-ahead window closes two sectors before target sector
// R17 - host missing the window waits one more revolution
// R18 - without look-ahead, poll answered as soon as seek completes
// R19 - controller notified when present sector equals addressed sector
// R20 - six-bit sector counter, divider 0..839, index clear has priority
`timescale 1ns/1ps
module dss_sector_sense
  import dss_pkg::*;
#(
  parameter logic [23:0] MS_CYC = 24'd40000,
  parameter logic [5:0] INDEX_PATTERN = INDEX_PATTERN_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog front end
  input wire logic sectorClk,
  input wire logic negative_peak_detect,
  output logic refClk,
  // drive control
  input wire logic new_pack_clear_n,
  input wire logic lookahead_strap,
  output logic index_pulse_n,
  output logic sector_match,
  output logic sectorReached,
  output logic pollRespond
);

  // synchronisers: stage one only feeds stage two
  logic [3:0] syncA_q;
  logic [3:0] syncB_q;
  logic sclkPrev_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      syncA_q <= 4'h4;
      syncB_q <= 4'h4;
      sclkPrev_q <= 1'b0;
    end else begin
      syncA_q <= {lookahead_strap, new_pack_clear_n, negative_peak_detect,
                  sectorClk};
      syncB_q <= syncA_q;
      sclkPrev_q <= syncB_q[0];
    end
  end

  logic sclkS;
  logic peakS;
  logic packClrS_n;
  logic strapS;
  assign sclkS = syncB_q[0];
  assign peakS = syncB_q[1];
  assign packClrS_n = syncB_q[2];
  assign strapS = syncB_q[3];

  logic sclkRise;
  logic sclkEdge;
  assign sclkRise = sclkS & ~sclkPrev_q;
  assign sclkEdge = sclkS ^ sclkPrev_q;

  // divide by eight reference
  logic [2:0] refDiv_q;
  logic refPrev_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      refDiv_q <= 3'h0;
    end else if (sclkRise) begin
      refDiv_q <= (refDiv_q == REF_DIV_LAST) ? 3'h0 : refDiv_q + 3'h1; // R1
    end
  end

  // trailing edge taken from the counter, a cycle ahead of refClk
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      refPrev_q <= 1'b0;
    end else begin
      refPrev_q <= refDiv_q[2];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      refClk <= 1'b0;
    end else begin
      refClk <= refDiv_q[2]; // R1
    end
  end

  logic refTrail;
  assign refTrail = refPrev_q & ~refDiv_q[2];

  // index detector
  logic peakHold_q;
  logic [SHIFT_LEN-1:0] shift_q;
  logic idxArmed_q;
  logic idxStart;
  assign idxStart = refTrail & idxArmed_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      peakHold_q <= 1'b0;
      shift_q <= '0;
    end else if (refTrail) begin
      shift_q <= {shift_q[SHIFT_LEN-2:0], peakHold_q}; // R2
      peakHold_q <= peakS;
    end else if (peakS) begin
      peakHold_q <= 1'b1; // R2
    end
  end

  // pattern seen on one trailing edge fires on the next
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idxArmed_q <= 1'b0;
    end else if (refTrail) begin
      idxArmed_q <= ({shift_q[PATTERN_LEN-2:0], peakHold_q}
                     == INDEX_PATTERN) & ~idxArmed_q; // R3
    end
  end

  logic [7:0] idxTimer_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idxTimer_q <= 8'h00;
      index_pulse_n <= 1'b1;
    end else if (idxStart) begin
      idxTimer_q <= 8'(IDX_PULSE_CYC - 1); // R4
      index_pulse_n <= 1'b0; // R3
    end else if (idxTimer_q != 8'h00) begin
      idxTimer_q <= idxTimer_q - 8'h01;
    end else begin
      index_pulse_n <= 1'b1; // R4
    end
  end

  // sector counting, 840 transitions per sector, 64 per revolution
  logic [9:0] secDiv_q;
  logic [5:0] secCnt_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      secDiv_q <= 10'h000;
      secCnt_q <= 6'h00;
    end else if (idxStart) begin
      secDiv_q <= 10'h000; // R7 R20
      secCnt_q <= 6'h00; // R7
    end else if (sclkEdge) begin
      if (secDiv_q == SEC_DIV_LAST) begin
        secDiv_q <= 10'h000; // R5 R20
        secCnt_q <= (secCnt_q == SEC_LAST) ? 6'h00 : secCnt_q + 6'h01; // R6
      end else begin
        secDiv_q <= secDiv_q + 10'h001; // R5
      end
    end
  end

  // one decode for every register word
  function automatic logic regHit(input logic [31:0] addr,
                                  input logic [7:0] ofs);
    return addr[7:0] == ofs && addr[31:8] == 24'h0;
  endfunction : regHit

  // apb access phases
  logic apbSetup;
  logic apbWrite;
  logic hitCtrl;
  logic hitAddr;
  logic hitStat;
  assign apbSetup = psel & ~penable;
  assign apbWrite = psel & penable & pready & pwrite;
  assign hitCtrl = regHit(paddr, CTRL_OFS);
  assign hitAddr = regHit(paddr, ADDR_OFS);
  assign hitStat = regHit(paddr, STAT_OFS);

  dss_ctrl_t ctrl_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
    end else if (apbWrite && hitCtrl) begin
      ctrl_q <= dss_ctrl_t'(pwdata[6:0]);
    end
  end

  // sector address register with legality check
  logic [5:0] secAddr_q;
  logic seekCheck_q;
  logic addrIllegal;
  assign addrIllegal = pwdata[5] & pwdata[4]; // R10

  always_ff @(posedge clk) begin
    if (!rst_n || !packClrS_n) begin
      secAddr_q <= SEC_ADDR_RST; // R8
    end else if (apbWrite && hitAddr && !addrIllegal) begin
      secAddr_q <= pwdata[5:0]; // R9
    end
  end

  // set wins over a software clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seekCheck_q <= 1'b0;
    end else if (apbWrite && hitAddr && addrIllegal) begin
      seekCheck_q <= 1'b1; // R11
    end else if (apbWrite && hitStat && pwdata[SEEK_CHECK_BIT]) begin
      seekCheck_q <= 1'b0;
    end
  end

  // sector compare
  logic secEqual;
  logic secEqualPrev_q;
  logic rwActive;
  assign secEqual = secAddr_q == secCnt_q; // R12
  assign rwActive = ctrl_q.readCmd | ctrl_q.writeCmd;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      secEqualPrev_q <= 1'b0;
    end else begin
      secEqualPrev_q <= secEqual;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sector_match <= 1'b0;
    end else if (!rwActive) begin
      sector_match <= 1'b0; // R14
    end else if (secEqual && !secEqualPrev_q) begin
      sector_match <= 1'b1; // R12 R13
    end else if (sclkEdge && secDiv_q == SEC_END_CNT) begin
      sector_match <= 1'b0; // R14
    end
  end

  // notify controller on each arrival at the addressed sector
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sectorReached <= 1'b0;
    end else begin
      sectorReached <= secEqual & ~secEqualPrev_q; // R19
    end
  end

  // look-ahead window, timed against the measured revolution
  logic [5:0] closeSec;
  logic [5:0] secPrev_q;
  logic closeEvt;
  logic [REV_W-1:0] sinceClose_q;
  logic [REV_W-1:0] revCyc_q;
  logic revValid_q;
  logic [REV_W-1:0] winLen;
  logic winOpen;
  logic [REV_W-1:0] openAt;
  assign closeSec = secAddr_q - LOOKAHEAD_SECS; // R16
  assign closeEvt = secCnt_q == closeSec && secPrev_q != secCnt_q;
  assign winLen = REV_W'({20'h0, ctrl_q.unitNum} + 24'h1) * MS_CYC;
  // subtract from the revolution so a saturated count cannot wrap
  assign openAt = (winLen >= revCyc_q) ? '0 : revCyc_q - winLen;
  assign winOpen = revValid_q && (sinceClose_q >= openAt); // R15

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      secPrev_q <= 6'h00;
    end else begin
      secPrev_q <= secCnt_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sinceClose_q <= '0;
      revCyc_q <= '0;
      revValid_q <= 1'b0;
    end else begin
      if (closeEvt) begin
        sinceClose_q <= '0; // R16
        revCyc_q <= sinceClose_q;
        revValid_q <= revValid_q | (sinceClose_q != '0);
      end else if (sinceClose_q != '1) begin
        sinceClose_q <= sinceClose_q + REV_W'(1);
      end
    end
  end

  // a missed window simply reopens one revolution later
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pollRespond <= 1'b0;
    end else if (!strapS) begin
      pollRespond <= ctrl_q.seekDone; // R18
    end else begin
      pollRespond <= ctrl_q.seekDone & winOpen & ~closeEvt; // R15 R17
    end
  end

  // apb answer: one access cycle, errors on unmapped words
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0;
    if (hitCtrl) begin
      rdMux = {25'h0, ctrl_q};
    end else if (hitAddr) begin
      rdMux = {26'h0, secAddr_q};
    end else if (hitStat) begin
      rdMux = {6'h0, secDiv_q, 2'h0, secCnt_q, 2'h0, pollRespond,
               sector_match, seekCheck_q, ~index_pulse_n, secEqual,
               strapS};
    end
  end

  // no wait states, so masters never stall on this block
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= apbSetup;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= apbSetup & ~(hitCtrl | hitAddr | hitStat);
    end
  end

  // read data is zero outside a read answer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= 32'h0;
    end else if (apbSetup && !pwrite) begin
      prdata <= rdMux;
    end else begin
      prdata <= 32'h0;
    end
  end

endmodule : dss_sector_sense

// ### verification/dss_sector_sense_asserts.sv
// Purpose: port checks for sector sensing
// Assumes: synchronous active low reset
// Notes: index width counted in helper logic
`timescale 1ns/1ps
module dss_sector_sense_asserts
  import dss_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // drive
  input wire logic refClk,
  input wire logic index_pulse_n,
  input wire logic sector_match,
  input wire logic sectorReached
);
  logic [7:0] lowCnt_q;
  always_ff @(posedge clk) begin
    if (!rst_n || index_pulse_n) lowCnt_q <= 8'h00;
    else lowCnt_q <= lowCnt_q + 8'h01;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_idx_width;
    $rose(index_pulse_n) |-> lowCnt_q == IDX_PULSE_CYC;
  endproperty
  a_idx_width: assert property (p_idx_width)
    else $error("index pulse width wrong");
  property p_idx_max;
    !index_pulse_n |-> lowCnt_q < IDX_PULSE_CYC;
  endproperty
  a_idx_max: assert property (p_idx_max)
    else $error("index pulse too long");
  property p_apb_answer;
    psel && !penable |=> pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("apb answer late");
  property p_apb_one;
    pready |=> !pready;
  endproperty
  a_apb_one: assert property (p_apb_one)
    else $error("pready stands too long");
  property p_slverr;
    pslverr |-> pready;
  endproperty
  a_slverr: assert property (p_slverr)
    else $error("pslverr without pready");
  property p_reached;
    sectorReached |=> !sectorReached;
  endproperty
  a_reached: assert property (p_reached)
    else $error("sector reached not a pulse");
  property p_match_cause;
    $rose(sector_match) |->
      sectorReached || $past(sectorReached) || $past(sectorReached, 2);
  endproperty
  a_match_cause: assert property (p_match_cause)
    else $error("sector match without equality");
  property p_ref_slow;
    $changed(refClk) |=> $stable(refClk) [*8];
  endproperty
  a_ref_slow: assert property (p_ref_slow)
    else $error("reference too fast");
endmodule : dss_sector_sense_asserts
bind dss_sector_sense dss_sector_sense_asserts dss_sector_sense_asserts_inst (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .refClk(refClk),
  .index_pulse_n(index_pulse_n), .sector_match(sector_match),
  .sectorReached(sectorReached));

// ### verification/dss_servo_model.sv
// Purpose: servo side source of sector clock and peak detect
// Assumes: design refClk paces the peak pattern
// Notes: sends the index pattern once, then silence; each bit is a
//   one-clock peak pulse, as a peak detector gives
`timescale 1ns/1ps
module dss_servo_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // servo side
  input wire logic refClk,
  output logic sectorClk,
  output logic negative_peak_detect
);
  logic [1:0] div_q;
  logic [11:0] pat_q;
  logic ref_q;
  // pll clock runs free, four clk per level, slow enough for sync
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_q <= 2'h0;
      sectorClk <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3) sectorClk <= !sectorClk;
    end
  end
  // pulse on ref rise, well clear of the trailing edge; a held level
  // would smear into the next bit through the hold flop
  always_ff @(posedge clk) begin
    ref_q <= refClk;
    if (!rst_n) begin
      pat_q <= 12'hb40;
      negative_peak_detect <= 1'b0;
    end else begin
      negative_peak_detect <= refClk & ~ref_q & pat_q[11];
      if (refClk && !ref_q) begin
        pat_q <= {pat_q[10:0], 1'b0};
      end
    end
  end
endmodule : dss_servo_model

// ### verification/test_dss_sector_sense.sv
// Purpose: self-checking bench for sector sensing
// Assumes: servo model supplies clock and index pattern
// Notes: full revolution too long to run, one index only
`timescale 1ns/1ps
module test_dss_sector_sense;
  import dss_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, gotErr;
  logic [31:0] paddr, pwdata, prdata, rdat;
  logic sectorClk, negative_peak_detect, refClk, new_pack_clear_n;
  logic lookahead_strap, index_pulse_n, sector_match, sectorReached;
  logic pollRespond;
  int errors, checks_done, cyc;
  dss_sector_sense #(.MS_CYC(24'd20)) dss_sector_sense_inst (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sectorClk(sectorClk),
    .negative_peak_detect(negative_peak_detect), .refClk(refClk),
    .new_pack_clear_n(new_pack_clear_n),
    .lookahead_strap(lookahead_strap), .index_pulse_n(index_pulse_n),
    .sector_match(sector_match), .sectorReached(sectorReached),
    .pollRespond(pollRespond));
  dss_servo_model dss_servo_model_inst (.clk(clk), .rst_n(rst_n),
    .refClk(refClk), .sectorClk(sectorClk),
    .negative_peak_detect(negative_peak_detect));
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h000000, a};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    gotErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic t_regs;
    apb(1'b0, ADDR_OFS, 32'h0);
    chk(rdat, 32'h0);
    apb(1'b1, ADDR_OFS, 32'h5);
    apb(1'b0, ADDR_OFS, 32'h0);
    chk(rdat, 32'h5);
    apb(1'b1, ADDR_OFS, 32'h30);
    apb(1'b0, ADDR_OFS, 32'h0);
    chk(rdat, 32'h5);
    apb(1'b0, STAT_OFS, 32'h0);
    chk(rdat & 32'h8, 32'h8);
    apb(1'b1, STAT_OFS, 32'h8);
    apb(1'b0, STAT_OFS, 32'h0);
    chk(rdat & 32'h8, 32'h0);
    apb(1'b1, ADDR_OFS, 32'h2f);
    apb(1'b0, ADDR_OFS, 32'h0);
    chk(rdat, 32'h2f);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, gotErr}, 32'h1);
    new_pack_clear_n <= 1'b0;
    repeat (6) @(posedge clk);
    new_pack_clear_n <= 1'b1;
    repeat (6) @(posedge clk);
    apb(1'b0, ADDR_OFS, 32'h0);
    chk(rdat, 32'h0);
    $display("test regs done");
  endtask : t_regs
  task automatic t_index;
    @(posedge clk iff index_pulse_n === 1'b0);
    apb(1'b0, STAT_OFS, 32'h0);
    chk({26'h0, rdat[13:8]}, 32'h0);
    chk({31'h0, rdat[25:16] < 10'h020}, 32'h1);
    $display("test index done");
  endtask : t_index
  task automatic t_match;
    apb(1'b1, ADDR_OFS, 32'h1);
    apb(1'b1, CTRL_OFS, 32'h1);
    @(posedge clk iff sector_match === 1'b1);
    apb(1'b0, STAT_OFS, 32'h0);
    chk({26'h0, rdat[13:8]}, 32'h1);
    @(posedge clk iff sector_match === 1'b0);
    apb(1'b0, STAT_OFS, 32'h0);
    chk({31'h0, rdat[25:16] >= SEC_END_CNT}, 32'h1);
    chk({26'h0, rdat[13:8]}, 32'h1);
    apb(1'b1, ADDR_OFS, 32'h2);
    @(posedge clk iff sector_match === 1'b1);
    apb(1'b0, STAT_OFS, 32'h0);
    chk({26'h0, rdat[13:8]}, 32'h2);
    apb(1'b1, CTRL_OFS, 32'h0);
    repeat (2) @(posedge clk);
    chk({31'h0, sector_match}, 32'h0);
    $display("test match done");
  endtask : t_match
  task automatic t_poll;
    apb(1'b1, CTRL_OFS, 32'h4);
    repeat (4) @(posedge clk);
    chk({31'h0, pollRespond}, 32'h1);
    lookahead_strap <= 1'b1;
    repeat (6) @(posedge clk);
    chk({31'h0, pollRespond}, 32'h0);
    apb(1'b0, STAT_OFS, 32'h0);
    chk(rdat & 32'h1, 32'h1);
    lookahead_strap <= 1'b0;
    $display("test poll done");
  endtask : t_poll
  initial begin
    clk = 1'b0;
    forever #12.5 clk = !clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      tally_and_finish();
    end
  end
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    new_pack_clear_n = 1'b1;
    lookahead_strap = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs();
    t_index();
    t_match();
    t_poll();
    tally_and_finish();
  end
endmodule : test_dss_sector_sense
